// *** logic/fps_pkg.sv ***
// Purpose: Constants and types for the flash program/erase sequencer.
// Assumes: 14-bit flash byte address, 512-byte pages, 100 MHz clock.
// Notes: Each rule below is tagged at the logic that carries it out.
package fps_pkg;
  localparam int          ADDR_W         = 14;
  localparam int          DEPTH          = 16384;
  localparam int          PAGE_BITS      = 9;
  localparam logic [7:0]  TRIG_FIRST     = 8'h46;
  localparam logic [7:0]  TRIG_SECOND    = 8'hB9;
  localparam logic [2:0]  MODE_ERASE     = 3'h3;
  localparam logic [2:0]  MODE_PROGRAM   = 3'h2;
  localparam logic [2:0]  MODE_READ      = 3'h1;
  localparam logic [2:0]  SWR_TO_APP     = 3'h5;
  localparam logic [2:0]  SWR_TO_APP_ALT = 3'h1;
  localparam logic [2:0]  SWR_TO_LOADER  = 3'h7;
  localparam int          CTRL_EN_BIT    = 7;
  localparam logic [7:0]  DATA_RESET     = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int          CLK_MHZ        = 100;
  localparam int          TICK_NS        = 1000;
  localparam int          TICK_CYC       = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0]  DIV_TICKS_PROG = 6'h04;
  typedef enum logic [2:0] {
    FPS_IDLE, FPS_WAIT, FPS_ERASE, FPS_PROG, FPS_READ, FPS_DONE
  } fps_state_t;
endpackage

// *** logic/fps_flash_mem.sv ***
// Purpose: Flash array model with registered read data.
// Assumes: One access per clock.
// Notes: Read-modify for programming is done by the sequencer.
`timescale 1ns/100ps
module fps_flash_mem (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_we,
  input  wire logic [fps_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]                  i_wdata,
  output logic      [7:0]                  o_rdata
);
  logic [7:0] mem [fps_pkg::DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule // fps_flash_mem

// *** logic/fps_sequencer.sv ***
// Purpose: Trigger decode, address range check, erase/program/read sequencing, resets.
// Assumes: CPU writes arrive as one-cycle strobes on the same clock.
// Notes: Region boundaries come in as configuration ports.
`timescale 1ns/100ps
module fps_sequencer (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_por,
  input  wire logic                        i_ctrl_we,
  input  wire logic [7:0]                  i_ctrl_wdata,
  input  wire logic                        i_mode_we,
  input  wire logic [7:0]                  i_mode_wdata,
  input  wire logic                        i_addr_high_we,
  input  wire logic                        i_addr_low_we,
  input  wire logic                        i_data_we,
  input  wire logic                        i_trig_we,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic [5:0]                  i_flash_clock_divider,
  input  wire logic                        i_boot_from_loader_option,
  input  wire logic                        i_boot_after_ext_reset_option,
  input  wire logic                        i_loader_valid,
  input  wire logic [fps_pkg::ADDR_W-1:0]  i_loader_start,
  input  wire logic [fps_pkg::ADDR_W-1:0]  i_data_low,
  input  wire logic [fps_pkg::ADDR_W-1:0]  i_fetch_addr,
  output logic      [fps_pkg::ADDR_W-1:0]  o_fetch_phys,
  output logic      [7:0]                  o_flash_data_port,
  output logic      [7:0]                  o_flash_addr_high,
  output logic      [7:0]                  o_flash_addr_low,
  output logic      [7:0]                  o_flash_access_control,
  output logic      [2:0]                  o_operation_select_field,
  output logic                             o_cpu_stall,
  output logic                             o_irq_hold,
  output logic                             o_sw_reset,
  output logic                             o_in_loader,
  output logic                             o_trig_ignored
);
  logic [7:0]                 data_r;
  logic [7:0]                 ah_r;
  logic [7:0]                 al_r;
  logic [7:0]                 ctrl_r;
  logic [2:0]                 mode_r;
  logic                       armed_r;
  logic                       in_loader_r;
  logic                       swr_r;
  logic                       ign_r;
  fps_pkg::fps_state_t        st_r;
  logic [5:0]                 tick_r;
  logic [fps_pkg::ADDR_W-1:0] op_addr_r;
  logic [fps_pkg::PAGE_BITS-1:0] page_cnt_r;
  logic                       mem_we;
  logic [fps_pkg::ADDR_W-1:0] mem_addr;
  logic [7:0]                 mem_wdata;
  logic [7:0]                 mem_rdata;
  logic [fps_pkg::ADDR_W-1:0] tgt;
  logic                       trig_ok;
  logic                       in_range;
  logic                       cnt_done;

  function automatic logic mode_known(input logic [2:0] m);
    return (m == fps_pkg::MODE_ERASE) || (m == fps_pkg::MODE_PROGRAM) ||
           (m == fps_pkg::MODE_READ);
  endfunction

  assign tgt = {ah_r[fps_pkg::ADDR_W-9:0], al_r};
  // From the loader any application or data byte below the loader is legal;
  // from the application only the data region below the loader is legal.
  always_comb begin
    if (in_loader_r) begin
      in_range = (tgt < i_loader_start) || !i_loader_valid;
    end else begin
      in_range = (tgt >= i_data_low) &&
                 ((tgt < i_loader_start) || !i_loader_valid);
    end
  end
  assign trig_ok = i_trig_we && armed_r && (i_wdata == fps_pkg::TRIG_SECOND) &&
                   ctrl_r[fps_pkg::CTRL_EN_BIT] && mode_known(mode_r) &&
                   (st_r == fps_pkg::FPS_IDLE);

  // A stray byte disarms, so a half-written sequence never pairs with a later B9h.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      armed_r <= 1'b0;
    end else if (i_trig_we) begin
      armed_r <= (i_wdata == fps_pkg::TRIG_FIRST);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ah_r   <= 8'h00;
      al_r   <= 8'h00;
      mode_r <= 3'h0;
    end else begin
      if (i_addr_high_we) begin
        ah_r <= i_wdata;
      end
      if (i_addr_low_we) begin
        al_r <= i_wdata;
      end
      if (i_mode_we) begin
        mode_r <= i_mode_wdata[2:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      data_r <= fps_pkg::DATA_RESET;
    end else if (st_r == fps_pkg::FPS_DONE && mode_r == fps_pkg::MODE_READ) begin
      data_r <= mem_rdata;
    end else if (i_data_we) begin
      data_r <= i_wdata;
    end
  end

  // Software reset: the top three bits are matched only when written together.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_r <= 8'h00;
      swr_r  <= 1'b0;
    end else begin
      swr_r <= 1'b0;
      if (i_ctrl_we) begin
        ctrl_r <= i_ctrl_wdata;
        if (i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_APP ||
            i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_APP_ALT) begin
          swr_r <= 1'b1;
        end else if (i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_LOADER && !in_loader_r &&
                     i_loader_valid) begin
          swr_r <= 1'b1;
        end
      end
    end
  end

  // Boot region survives the synchronous reset; power-on is its own input.
  always_ff @(posedge i_ref_clk) begin
    if (i_por) begin
      in_loader_r <= i_boot_from_loader_option && i_loader_valid;
    end else if (!i_reset_n) begin
      if (!swr_r && i_boot_after_ext_reset_option && i_boot_from_loader_option &&
          i_loader_valid) begin
        in_loader_r <= 1'b1;
      end
    end else if (i_ctrl_we && i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_LOADER &&
                 !in_loader_r && i_loader_valid) begin
      in_loader_r <= 1'b1;
    end else if (i_ctrl_we && (i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_APP ||
                 i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_APP_ALT)) begin
      in_loader_r <= 1'b0;
    end
  end

  assign o_fetch_phys = in_loader_r ? (i_fetch_addr + i_loader_start) : i_fetch_addr;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ign_r <= 1'b0;
    end else begin
      ign_r <= trig_ok && !in_range;
    end
  end

  // The wait runs divider plus one cycles, so the old byte is read before a program.
  assign cnt_done = (tick_r == 6'h00);

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_r       <= fps_pkg::FPS_IDLE;
      op_addr_r  <= '0;
      page_cnt_r <= '0;
      tick_r     <= 6'h00;
    end else begin
      unique case (st_r)
        fps_pkg::FPS_IDLE: begin
          if (trig_ok && in_range) begin
            tick_r <= i_flash_clock_divider;
            st_r   <= fps_pkg::FPS_WAIT;
            if (mode_r == fps_pkg::MODE_ERASE) begin
              op_addr_r <= {tgt[fps_pkg::ADDR_W-1:fps_pkg::PAGE_BITS],
                            {fps_pkg::PAGE_BITS{1'b0}}};
            end else begin
              op_addr_r <= tgt;
            end
            page_cnt_r <= '0;
          end
        end
        fps_pkg::FPS_WAIT: begin
          if (cnt_done) begin
            unique case (mode_r)
              fps_pkg::MODE_ERASE:   st_r <= fps_pkg::FPS_ERASE;
              fps_pkg::MODE_PROGRAM: st_r <= fps_pkg::FPS_PROG;
              default:               st_r <= fps_pkg::FPS_READ;
            endcase
          end else begin
            tick_r <= tick_r - 6'h01;
          end
        end
        fps_pkg::FPS_ERASE: begin
          page_cnt_r <= page_cnt_r + 1'b1;
          if (&page_cnt_r) begin
            st_r <= fps_pkg::FPS_DONE;
          end
        end
        fps_pkg::FPS_PROG: begin
          st_r <= fps_pkg::FPS_DONE;
        end
        fps_pkg::FPS_READ: begin
          st_r <= fps_pkg::FPS_DONE;
        end
        fps_pkg::FPS_DONE: begin
          st_r <= fps_pkg::FPS_IDLE;
        end
        default: st_r <= fps_pkg::FPS_IDLE;
      endcase
    end
  end

  // Program reads the old byte during WAIT's last tick; ANDing keeps ones from reappearing.
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = op_addr_r;
    mem_wdata = fps_pkg::ERASED_BYTE;
    if (st_r == fps_pkg::FPS_ERASE) begin
      mem_we    = 1'b1;
      mem_addr  = {op_addr_r[fps_pkg::ADDR_W-1:fps_pkg::PAGE_BITS], page_cnt_r};
      mem_wdata = fps_pkg::ERASED_BYTE;
    end else if (st_r == fps_pkg::FPS_PROG) begin
      mem_we    = 1'b1;
      mem_wdata = mem_rdata & data_r;
    end
  end

  fps_flash_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_we      (mem_we),
    .i_addr    (mem_addr),
    .i_wdata   (mem_wdata),
    .o_rdata   (mem_rdata)
  );

  assign o_cpu_stall              = (st_r != fps_pkg::FPS_IDLE);
  assign o_irq_hold               = o_cpu_stall;
  assign o_flash_data_port        = data_r;
  assign o_flash_addr_high        = ah_r;
  assign o_flash_addr_low         = al_r;
  assign o_flash_access_control   = ctrl_r;
  assign o_operation_select_field = mode_r;
  assign o_sw_reset               = swr_r;
  assign o_in_loader              = in_loader_r;
  assign o_trig_ignored           = ign_r;

  stall_span_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (trig_ok && in_range) |=> o_cpu_stall) else $error("stall missing after trigger");
  stall_drop_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (st_r == fps_pkg::FPS_DONE) |=> !o_cpu_stall) else $error("stall held after done");
  ignore_trig_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (trig_ok && !in_range) |=> !o_cpu_stall && o_trig_ignored) else $error("bad trigger ran");
  seq_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_trig_we && i_wdata != fps_pkg::TRIG_FIRST) |=> !armed_r) else $error("arm kept");
  need_first_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_cpu_stall)) |-> $past(armed_r)) else $error("start without first byte");
  prog_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mem_we && st_r == fps_pkg::FPS_PROG) |-> ((mem_wdata & ~mem_rdata) == 8'h00))
    else $error("program set a bit");
  erase_ones_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (st_r == fps_pkg::FPS_ERASE) |-> mem_we && mem_wdata == 8'hFF)
    else $error("erase not ones");
  erase_align_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (st_r == fps_pkg::FPS_WAIT && mode_r == fps_pkg::MODE_ERASE) |->
    op_addr_r[fps_pkg::PAGE_BITS-1:0] == '0) else $error("page not aligned");
  read_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (st_r == fps_pkg::FPS_DONE && mode_r == fps_pkg::MODE_READ) |=> data_r == $past(mem_rdata))
    else $error("read data lost");
  irq_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_cpu_stall |-> o_irq_hold) else $error("irq not held");
  // The soft reset feeds straight back into the synchronous reset, so this check is gated
  // by the reset level at the write instead of being disabled by the reset it causes.
  swr_app_a: assert property (@(posedge i_ref_clk)
    (i_reset_n && i_ctrl_we && i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_APP) |=>
    o_sw_reset && !o_in_loader) else $error("app reset missing");
  swr_ldr_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (i_ctrl_we && i_ctrl_wdata[7:5] == fps_pkg::SWR_TO_LOADER && !i_loader_valid &&
     !in_loader_r) |=> !o_sw_reset) else $error("loader reset without region");
  boot_por_a: assert property (@(posedge i_ref_clk)
    (i_por && i_boot_from_loader_option && i_loader_valid) |=> o_in_loader)
    else $error("power-on boot not in loader");
  ext_boot_a: assert property (@(posedge i_ref_clk)
    (!i_reset_n && !i_por && !o_sw_reset && i_boot_after_ext_reset_option &&
     i_boot_from_loader_option && i_loader_valid) |=> o_in_loader) else $error("ext boot lost");
  app_range_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (trig_ok && !in_loader_r && tgt < i_data_low) |=> o_trig_ignored && !o_cpu_stall)
    else $error("trigger below data region ran");
  ldr_region_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (trig_ok && in_loader_r && i_loader_valid && tgt >= i_loader_start) |=>
    o_trig_ignored && !o_cpu_stall) else $error("loader region written");

  erase_run_c: cover property (@(posedge i_ref_clk) st_r == fps_pkg::FPS_ERASE ##1
    st_r == fps_pkg::FPS_ERASE);
  prog_run_c: cover property (@(posedge i_ref_clk) st_r == fps_pkg::FPS_PROG);
  read_run_c: cover property (@(posedge i_ref_clk) st_r == fps_pkg::FPS_READ);
  ignored_c: cover property (@(posedge i_ref_clk) o_trig_ignored);
  soft_reset_c: cover property (@(posedge i_ref_clk) o_sw_reset);
endmodule // fps_sequencer

// *** sim/fps_cpu_model.sv ***
// Purpose: Core-side model that writes the sequencer registers as one-cycle strobes.
// Assumes: Strobe index 0 control, 1 mode, 2 address high, 3 address low, 4 data, 5 trigger.
// Notes: Released data shows the inverse of the last value, so stale bytes are never reused.
`timescale 1ns/100ps
module fps_cpu_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_cpu_stall,
  output logic      [5:0] o_we,
  output logic      [7:0] o_data
);
  initial begin
    o_we   = 6'h00;
    o_data = 8'h00;
  end

  // A frozen core issues nothing, and trigger bytes go out in call order.
  task automatic wr(input int sel, input logic [7:0] d);
    int n;
    n = 0;
    while (i_cpu_stall === 1'b1 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
    @(posedge i_ref_clk);
    #1;
    o_we[sel] = 1'b1;
    o_data    = d;
    @(posedge i_ref_clk);
    #1;
    o_we      = 6'h00;
    o_data    = ~d;
  endtask
endmodule // fps_cpu_model

// *** sim/flash_program_erase_sequencer_tb_top.sv ***
// Purpose: Self-checking bench for the flash program/erase sequencer.
// Assumes: Divider of 2 keeps waits short; loader region starts at 3A00h, data region at 3600h.
// Notes: The soft reset pulse is fed back into the synchronous reset, as the core would be.
`timescale 1ns/100ps
module flash_program_erase_sequencer_tb_top;
  localparam logic [5:0]  DIV    = 6'h02;
  localparam logic [13:0] LD_ST  = 14'h3A00;
  localparam logic [13:0] DAT_LO = 14'h3600;
  localparam int          PC     = int'(DIV) + 3;
  localparam int          EC     = int'(DIV) + 2 + (1 << fps_pkg::PAGE_BITS);
  logic        clk;
  logic        rst_n;
  logic        por;
  logic        boot_opt;
  logic        ext_opt;
  logic        ld_valid;
  logic [13:0] fetch;
  logic [5:0]  we;
  logic [7:0]  cd;
  logic [13:0] phys;
  logic [7:0]  dport;
  logic [7:0]  ah;
  logic [7:0]  al;
  logic [7:0]  ctrl_q;
  logic [2:0]  ms_q;
  logic        stall;
  logic        irq_hold;
  logic        swr;
  logic        in_ld;
  logic        ign;
  int          n_mismatch;
  int          num_checks;

  fps_cpu_model cpu_u (.i_ref_clk(clk), .i_cpu_stall(stall), .o_we(we), .o_data(cd));

  fps_sequencer dut_u (
    .i_ref_clk(clk), .i_reset_n(rst_n & ~swr), .i_por(por),
    .i_ctrl_we(we[0]), .i_ctrl_wdata(cd), .i_mode_we(we[1]), .i_mode_wdata(cd),
    .i_addr_high_we(we[2]), .i_addr_low_we(we[3]), .i_data_we(we[4]), .i_trig_we(we[5]),
    .i_wdata(cd), .i_flash_clock_divider(DIV), .i_boot_from_loader_option(boot_opt),
    .i_boot_after_ext_reset_option(ext_opt), .i_loader_valid(ld_valid),
    .i_loader_start(LD_ST), .i_data_low(DAT_LO), .i_fetch_addr(fetch), .o_fetch_phys(phys),
    .o_flash_data_port(dport), .o_flash_addr_high(ah), .o_flash_addr_low(al),
    .o_flash_access_control(ctrl_q), .o_operation_select_field(ms_q), .o_cpu_stall(stall),
    .o_irq_hold(irq_hold), .o_sw_reset(swr), .o_in_loader(in_ld), .o_trig_ignored(ign));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One full operation; stall length and read data are judged once the core is released.
  task automatic op(input logic [2:0] m, input logic [13:0] a, input logic [7:0] d,
                    input logic ign_exp, input int cycles, input logic [7:0] rd_exp);
    int n;
    n = 0;
    cpu_u.wr(0, 8'h80);
    cpu_u.wr(1, {5'h00, m});
    cpu_u.wr(2, {2'b00, a[13:8]});
    cpu_u.wr(3, a[7:0]);
    cpu_u.wr(4, d);
    chk("op_select", {13'h0000, m}, {13'h0000, ms_q});
    chk("addr_high", {10'h000, a[13:8]}, {8'h00, ah});
    chk("addr_low", {8'h00, a[7:0]}, {8'h00, al});
    chk("data_port", {8'h00, d}, {8'h00, dport});
    chk("ctrl", 16'h0080, {8'h00, ctrl_q});
    cpu_u.wr(5, fps_pkg::TRIG_FIRST);
    cpu_u.wr(5, fps_pkg::TRIG_SECOND);
    if (ign_exp) begin
      chk("trig_ignored", 16'h0001, {15'h0, ign});
      chk("stall", 16'h0000, {15'h0, stall});
    end else begin
      while (stall === 1'b1 && n < 2000) begin
        chk("irq_hold", 16'h0001, {15'h0, irq_hold});
        cyc(1);
        n++;
      end
      chk("stall_cycles", cycles[15:0], n[15:0]);
      if (m === fps_pkg::MODE_READ) chk("data_port", {8'h00, rd_exp}, {8'h00, dport});
    end
    cpu_u.wr(1, 8'h00);
    cpu_u.wr(0, 8'h00);
  endtask

  task automatic t_reset();
    chk("data_port", 16'h00FF, {8'h00, dport});
    chk("addr_high", 16'h0000, {8'h00, ah});
    chk("addr_low", 16'h0000, {8'h00, al});
    chk("ctrl", 16'h0000, {8'h00, ctrl_q});
    chk("stall", 16'h0000, {15'h0, stall});
    chk("in_loader", 16'h0001, {15'h0, in_ld});
    fetch = 14'h0010;
    #1;
    chk("fetch_phys", {2'b00, LD_ST + 14'h0010}, {2'b00, phys});
  endtask

  task automatic t_flash();
    op(fps_pkg::MODE_ERASE, 14'h0000, 8'h00, 1'b0, EC, 8'h00);
    op(fps_pkg::MODE_ERASE, 14'h0200, 8'h00, 1'b0, EC, 8'h00);
    op(fps_pkg::MODE_PROGRAM, 14'h0100, 8'h5A, 1'b0, PC, 8'h00);
    op(fps_pkg::MODE_READ, 14'h0100, 8'h00, 1'b0, PC, 8'h5A);
    op(fps_pkg::MODE_PROGRAM, 14'h0100, 8'hA5, 1'b0, PC, 8'h00);
    op(fps_pkg::MODE_READ, 14'h0100, 8'h00, 1'b0, PC, 8'h00);
    op(fps_pkg::MODE_PROGRAM, 14'h0200, 8'h3C, 1'b0, PC, 8'h00);
    op(fps_pkg::MODE_ERASE, 14'h0000, 8'h00, 1'b0, EC, 8'h00);
    op(fps_pkg::MODE_READ, 14'h0100, 8'h00, 1'b0, PC, 8'hFF);
    op(fps_pkg::MODE_READ, 14'h0200, 8'h00, 1'b0, PC, 8'h3C);
  endtask

  task automatic t_trig();
    cpu_u.wr(0, 8'h80);
    cpu_u.wr(1, {5'h00, fps_pkg::MODE_READ});
    cpu_u.wr(5, 8'hB9);
    chk("stall", 16'h0000, {15'h0, stall});
    cpu_u.wr(5, 8'h46);
    cpu_u.wr(5, 8'h12);
    cpu_u.wr(5, 8'hB9);
    chk("stall", 16'h0000, {15'h0, stall});
    cyc(2);
    chk("stall", 16'h0000, {15'h0, stall});
    cpu_u.wr(0, 8'h00);
    op(fps_pkg::MODE_PROGRAM, LD_ST, 8'h00, 1'b1, 0, 8'h00);
    op(fps_pkg::MODE_PROGRAM, 14'h3FFF, 8'h00, 1'b1, 0, 8'h00);
  endtask

  task automatic t_boot();
    cpu_u.wr(0, 8'hA0);
    chk("sw_reset", 16'h0001, {15'h0, swr});
    cyc(3);
    chk("in_loader", 16'h0000, {15'h0, in_ld});
    chk("fetch_phys", {2'b00, fetch}, {2'b00, phys});
    op(fps_pkg::MODE_PROGRAM, 14'h0100, 8'h00, 1'b1, 0, 8'h00);
    op(fps_pkg::MODE_PROGRAM, DAT_LO, 8'h00, 1'b0, PC, 8'h00);
    op(fps_pkg::MODE_READ, DAT_LO, 8'h00, 1'b0, PC, 8'h00);
    cpu_u.wr(0, 8'hE0);
    cyc(3);
    chk("in_loader", 16'h0001, {15'h0, in_ld});
    cpu_u.wr(0, 8'h20);
    cyc(3);
    chk("in_loader", 16'h0000, {15'h0, in_ld});
    ld_valid = 1'b0;
    cpu_u.wr(0, 8'hE0);
    cyc(3);
    chk("in_loader", 16'h0000, {15'h0, in_ld});
    ld_valid = 1'b1;
    do_reset();
    cyc(1);
    chk("in_loader", 16'h0000, {15'h0, in_ld});
    ext_opt = 1'b1;
    do_reset();
    cyc(1);
    chk("in_loader", 16'h0001, {15'h0, in_ld});
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    rst_n      = 1'b0;
    por        = 1'b1;
    boot_opt   = 1'b1;
    ext_opt    = 1'b0;
    ld_valid   = 1'b1;
    fetch      = 14'h0000;
    do_reset();
    por = 1'b0;
    cyc(1);
    t_reset();
    t_flash();
    t_trig();
    t_boot();
    finish_test();
  end
endmodule // flash_program_erase_sequencer_tb_top
